/* File: pkg/tsg_pkg.sv */
// constants for the television sync pulse generator
package tsg_pkg;
  // ---------------------------------------------------------------
  // clock and times
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int SC_RESET_MAX_NS = 200;
  localparam int SC_RESET_MAX_CYC_I = (SC_RESET_MAX_NS / CLK_NS < 1) ? 1 :
                                      SC_RESET_MAX_NS / CLK_NS;
  localparam logic [1:0] SC_RESET_MAX_CYC = 2'(SC_RESET_MAX_CYC_I);
  localparam int LOCK_ACQUIRE_MS = 34;
  localparam int LOCK_ACQUIRE_CYC_DEF = LOCK_ACQUIRE_MS * 1000000 / CLK_NS;
  localparam int LOCK_TIMER_W = 19;
  // ---------------------------------------------------------------
  // divider chain
  // ---------------------------------------------------------------
  localparam logic [2:0] PRESC_LAST = 3'h6;
  localparam logic [6:0] UNIT_LAST = 7'h40;
  localparam logic [9:0] HALF_LINE_LAST = 10'h20c;
  localparam logic [6:0] LEAD_MONO_UNITS = 7'h04;
  localparam logic [6:0] LEAD_COLOUR_UNITS = 7'h01;
  localparam logic [2:0] LEAD_PIPE_CLK = 3'h2;
  // ---------------------------------------------------------------
  // decode positions in units of one sixty-fifth half line; the vertical ends are counted in half lines
  // ---------------------------------------------------------------
  localparam logic [6:0] HSYNC_W = 7'h0a;
  localparam logic [6:0] EQ_W = 7'h05;
  localparam logic [6:0] BROAD_W = 7'h37;
  localparam logic [6:0] HDRIVE_W = 7'h0d;
  localparam logic [6:0] BLANK_TAIL_START = 7'h3e;
  localparam logic [6:0] BLANK_HEAD_END = 7'h13;
  localparam logic [6:0] BURST_START = 7'h0b;
  localparam logic [6:0] BURST_END = 7'h10;
  localparam logic [9:0] EQ1_END = 10'h006;
  localparam logic [9:0] BROAD_END = 10'h00c;
  localparam logic [9:0] EQ2_END = 10'h012;
  localparam logic [9:0] VDRIVE_END = 10'h012;
  localparam logic [9:0] VBLANK_END = 10'h02a;
  // ---------------------------------------------------------------
  // lock detector thresholds in units
  // ---------------------------------------------------------------
  localparam logic [7:0] FULL_LINE_MIN = 8'h62;
  localparam logic [7:0] EQ_WIDTH_MAX = 8'h08;
  localparam logic [7:0] COUNT_SAT = 8'hff;
endpackage : tsg_pkg

/* File: pkg/tsg_tick_if.sv */
// carrier between the timing chain and the lock detector
`timescale 1ns/1ps
interface tsg_tick_if;
  logic unit_tick;
  logic sync_in;
  logic lead_edge;
  logic lock_load;
  modport chain (output unit_tick, output sync_in, input lead_edge, input lock_load);
  modport det (input unit_tick, input sync_in, output lead_edge, output lock_load);
endinterface : tsg_tick_if

/* File: rtl/tsg_subcarrier.sv */
// four-state johnson counter for the colour subcarrier
`timescale 1ns/1ps
module tsg_subcarrier #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  output logic subcarrier
);
  logic [STAGES-1:0] q;
  logic [STAGES-1:0] next_q;

  // ---------------------------------------------------------------
  // johnson shift, cleared while stopped
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_stage
      if (i == 0) begin : g_head
        assign next_q[i] = run & ~q[STAGES-1];
      end else begin : g_body
        assign next_q[i] = run & q[i-1];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // restarts on the first clock after run rises
  assign subcarrier = q[STAGES-1];
endmodule : tsg_subcarrier

/* File: rtl/tsg_lock_detect.sv */
// finds the first equalizing pulse of the odd field on sync input
`timescale 1ns/1ps
module tsg_lock_detect (
  input wire logic clk,
  input wire logic resetn,
  tsg_tick_if.det bus
);
  logic sync_q;
  logic [7:0] interval;
  logic [7:0] width;
  logic prev_full;
  logic [7:0] next_interval;
  logic [7:0] next_width;
  logic next_prev_full;
  logic rise;
  logic fall;

  assign rise = bus.sync_in & ~sync_q;
  assign fall = ~bus.sync_in & sync_q;

  // ---------------------------------------------------------------
  // spacing and width measure
  // ---------------------------------------------------------------
  always_comb begin
    next_interval = interval;
    next_width = width;
    next_prev_full = prev_full;
    if (rise) begin
      next_prev_full = (interval >= tsg_pkg::FULL_LINE_MIN);
      next_interval = '0;
      next_width = '0;
    end else if (bus.unit_tick) begin
      if (interval != tsg_pkg::COUNT_SAT) begin
        next_interval = interval + 8'h01;
      end
      if (bus.sync_in && width != tsg_pkg::COUNT_SAT) begin
        next_width = width + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= 1'b0;
      interval <= '0;
      width <= '0;
      prev_full <= 1'b0;
    end else begin
      sync_q <= bus.sync_in;
      interval <= next_interval;
      width <= next_width;
      prev_full <= next_prev_full;
    end
  end

  // narrow pulse a full line after the last one opens the odd field
  assign bus.lead_edge = rise;
  assign bus.lock_load = fall & prev_full & (width < tsg_pkg::EQ_WIDTH_MAX);
endmodule : tsg_lock_detect

/* File: rtl/tsg_top.sv */
// sync pulse generator: divider chain, decoders, mode and gen-lock
`timescale 1ns/1ps
module tsg_top #(
  parameter int LOCK_ACQUIRE_CYC = tsg_pkg::LOCK_ACQUIRE_CYC_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic colour_mono_select,
  input wire logic comp_sync_in,
  output logic h_drive,
  output logic v_drive,
  output logic comp_sync,
  output logic comp_blank,
  output logic burst_flag,
  output logic odd_field_pulse,
  output logic even_field_pulse,
  output logic subcarrier,
  output logic mono_active,
  output logic genlock_locked
);
  tsg_tick_if u_if ();

  // ---------------------------------------------------------------
  // mode select filter
  // ---------------------------------------------------------------
  logic [1:0] low_cnt;
  logic mono_mode;
  logic [1:0] next_low_cnt;
  logic next_mono_mode;
  logic low_full;

  assign low_full = low_cnt == tsg_pkg::SC_RESET_MAX_CYC;

  always_comb begin
    next_low_cnt = low_cnt;
    next_mono_mode = mono_mode;
    if (colour_mono_select) begin
      next_low_cnt = '0;
      next_mono_mode = 1'b0;
    end else if (low_full) begin
      next_mono_mode = 1'b1;
    end else begin
      next_low_cnt = low_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= '0;
      mono_mode <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      mono_mode <= next_mono_mode;
    end
  end

  // ---------------------------------------------------------------
  // subcarrier
  // ---------------------------------------------------------------
  tsg_subcarrier #(
    .STAGES(2)
  ) u_sc (
    .clk(clk),
    .resetn(resetn),
    .run(colour_mono_select),
    .subcarrier(subcarrier)
  );

  // ---------------------------------------------------------------
  // lock detector
  // ---------------------------------------------------------------
  tsg_lock_detect u_det (
    .clk(clk),
    .resetn(resetn),
    .bus(u_if.det)
  );

  // ---------------------------------------------------------------
  // divider chain and shadow chain
  // ---------------------------------------------------------------
  logic [2:0] presc;
  logic [6:0] unit;
  logic h_half;
  logic [9:0] half_line;
  logic odd_field;
  logic [2:0] sh_presc;
  logic [6:0] sh_unit;
  logic [2:0] next_presc;
  logic [6:0] next_unit;
  logic next_h_half;
  logic [9:0] next_half_line;
  logic next_odd_field;
  logic [2:0] next_sh_presc;
  logic [6:0] next_sh_unit;
  logic unit_tick;
  logic sh_tick;
  logic unit_wrap;
  logic field_wrap;
  logic sh_wrap;

  // monochrome skips the divide-by-7 stage
  assign unit_tick = mono_mode | (presc == tsg_pkg::PRESC_LAST);
  assign sh_tick = mono_mode | (sh_presc == tsg_pkg::PRESC_LAST);
  assign u_if.unit_tick = unit_tick;
  assign u_if.sync_in = comp_sync_in;
  assign unit_wrap = unit == tsg_pkg::UNIT_LAST;
  assign field_wrap = half_line == tsg_pkg::HALF_LINE_LAST;
  assign sh_wrap = sh_unit == tsg_pkg::UNIT_LAST;

  always_comb begin
    next_presc = presc;
    next_unit = unit;
    next_h_half = h_half;
    next_half_line = half_line;
    next_odd_field = odd_field;
    next_sh_presc = sh_presc;
    next_sh_unit = sh_unit;
    // shadow chain tracks where the output must be relative to input
    // lead gains two clocks: input sample and output flop
    if (u_if.lead_edge) begin
      if (mono_mode) begin
        next_sh_presc = '0;
        next_sh_unit = tsg_pkg::LEAD_MONO_UNITS + {4'h0, tsg_pkg::LEAD_PIPE_CLK};
      end else begin
        next_sh_presc = tsg_pkg::LEAD_PIPE_CLK;
        next_sh_unit = tsg_pkg::LEAD_COLOUR_UNITS;
      end
    end else if (sh_tick) begin
      next_sh_presc = '0;
      next_sh_unit = sh_wrap ? 7'h00 : sh_unit + 7'h01;
    end else begin
      next_sh_presc = sh_presc + 3'h1;
    end
    // main chain
    if (u_if.lock_load) begin
      next_presc = next_sh_presc;
      next_unit = next_sh_unit;
      next_h_half = 1'b0;
      next_half_line = '0;
      next_odd_field = 1'b1;
    end else if (unit_tick) begin
      next_presc = '0;
      if (unit_wrap) begin
        next_unit = '0;
        next_h_half = ~h_half;
        if (field_wrap) begin
          next_half_line = '0;
          next_odd_field = ~odd_field;
        end else begin
          next_half_line = half_line + 10'h001;
        end
      end else begin
        next_unit = unit + 7'h01;
      end
    end else begin
      next_presc = presc + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc <= '0;
      unit <= '0;
      h_half <= 1'b0;
      half_line <= '0;
      odd_field <= 1'b1;
      sh_presc <= '0;
      sh_unit <= '0;
    end else begin
      presc <= next_presc;
      unit <= next_unit;
      h_half <= next_h_half;
      half_line <= next_half_line;
      odd_field <= next_odd_field;
      sh_presc <= next_sh_presc;
      sh_unit <= next_sh_unit;
    end
  end

  // ---------------------------------------------------------------
  // line and field decoders
  // ---------------------------------------------------------------
  logic next_h_drive;
  logic next_v_drive;
  logic next_comp_sync;
  logic next_comp_blank;
  logic next_burst_flag;
  logic next_odd_pulse;
  logic next_even_pulse;
  logic line_start;
  logic in_vsync;
  logic field_start;
  logic vblank;
  logic blank_head;
  logic blank_tail;
  logic burst_window;
  typedef enum logic [1:0] {
    REGION_EQ,
    REGION_BROAD,
    REGION_LINE
  } tsg_region_t;
  tsg_region_t region;

  assign line_start = ~h_half;
  assign in_vsync = half_line < tsg_pkg::EQ2_END;
  assign field_start = half_line == '0;
  assign vblank = half_line < tsg_pkg::VBLANK_END;
  assign blank_head = line_start & (unit < tsg_pkg::BLANK_HEAD_END);
  assign blank_tail = h_half & (unit >= tsg_pkg::BLANK_TAIL_START);
  assign burst_window = line_start & (unit >= tsg_pkg::BURST_START) &
                        (unit < tsg_pkg::BURST_END);

  // class of each half line in the vertical interval
  always_comb begin
    if (half_line < tsg_pkg::EQ1_END) begin
      region = REGION_EQ;
    end else if (half_line < tsg_pkg::BROAD_END) begin
      region = REGION_BROAD;
    end else if (half_line < tsg_pkg::EQ2_END) begin
      region = REGION_EQ;
    end else begin
      region = REGION_LINE;
    end
  end

  always_comb begin
    next_h_drive = line_start & (unit < tsg_pkg::HDRIVE_W);
    next_v_drive = half_line < tsg_pkg::VDRIVE_END;
    // composite sync: equalizing, broad or line sync per half line
    case (region)
      REGION_EQ: begin
        next_comp_sync = unit < tsg_pkg::EQ_W;
      end
      REGION_BROAD: begin
        next_comp_sync = unit < tsg_pkg::BROAD_W;
      end
      default: begin
        next_comp_sync = line_start & (unit < tsg_pkg::HSYNC_W);
      end
    endcase
    next_comp_blank = vblank | blank_tail | blank_head;
    // burst only in colour and outside the vertical sync interval
    next_burst_flag = ~mono_mode & ~in_vsync & burst_window;
    next_odd_pulse = odd_field & field_start;
    next_even_pulse = ~odd_field & field_start;
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_drive <= 1'b0;
      v_drive <= 1'b0;
      comp_sync <= 1'b0;
      comp_blank <= 1'b0;
      burst_flag <= 1'b0;
      odd_field_pulse <= 1'b0;
      even_field_pulse <= 1'b0;
      mono_active <= 1'b0;
    end else begin
      h_drive <= next_h_drive;
      v_drive <= next_v_drive;
      comp_sync <= next_comp_sync;
      comp_blank <= next_comp_blank;
      burst_flag <= next_burst_flag;
      odd_field_pulse <= next_odd_pulse;
      even_field_pulse <= next_even_pulse;
      mono_active <= mono_mode;
    end
  end

  // ---------------------------------------------------------------
  // lock status
  // ---------------------------------------------------------------
  logic [tsg_pkg::LOCK_TIMER_W-1:0] lock_timer;
  logic [tsg_pkg::LOCK_TIMER_W-1:0] next_lock_timer;
  logic next_locked;
  logic lock_expired;
  localparam logic [tsg_pkg::LOCK_TIMER_W-1:0] LOCK_LAST =
    tsg_pkg::LOCK_TIMER_W'(LOCK_ACQUIRE_CYC - 1);

  assign lock_expired = lock_timer == LOCK_LAST;

  always_comb begin
    next_lock_timer = lock_timer;
    next_locked = genlock_locked;
    if (u_if.lock_load) begin
      next_lock_timer = '0;
      next_locked = 1'b1;
    end else if (lock_expired) begin
      next_locked = 1'b0;
    end else begin
      next_lock_timer = lock_timer + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_timer <= '0;
      genlock_locked <= 1'b0;
    end else begin
      lock_timer <= next_lock_timer;
      genlock_locked <= next_locked;
    end
  end
endmodule : tsg_top

/* File: tb/tsg_chk.sv */
// port assertions for the sync generator
`timescale 1ns/1ps
module tsg_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic colour_mono_select,
  input wire logic h_drive,
  input wire logic v_drive,
  input wire logic burst_flag,
  input wire logic odd_field_pulse,
  input wire logic even_field_pulse,
  input wire logic subcarrier,
  input wire logic mono_active,
  input wire logic genlock_locked
);
  // ----------------
  // run counters
  // ----------------
  logic [9:0] hd_len;
  logic [9:0] hd_gap;
  logic [9:0] bf_len;
  logic [9:0] quiet;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hd_len <= 10'h000;
      hd_gap <= 10'h000;
      bf_len <= 10'h000;
      quiet <= 10'h000;
    end else begin
      hd_len <= h_drive ? hd_len + 10'h001 : 10'h000;
      hd_gap <= $rose(h_drive) ? 10'h001 : hd_gap + 10'h001;
      bf_len <= burst_flag ? bf_len + 10'h001 : 10'h000;
      quiet <= (colour_mono_select == mono_active || $rose(genlock_locked)) ? 10'h000 :
               quiet + {9'h000, ~&quiet};
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  hdrive_width_a: assert property ($fell(h_drive) && (&quiet) |->
    hd_len == (mono_active ? 10'h00d : 10'h05b)) else $error("h_drive width wrong");
  hdrive_period_a: assert property ($rose(h_drive) && (&quiet) |->
    hd_gap == (mono_active ? 10'h082 : 10'h38e)) else $error("h_drive period wrong");
  burst_width_a: assert property ($fell(burst_flag) && (&quiet) |->
    bf_len == 10'h023) else $error("burst width wrong");
  burst_mono_a: assert property (mono_active && $past(mono_active) |->
    !burst_flag) else $error("burst in mono");
  sub_reset_a: assert property (!colour_mono_select |=> !subcarrier)
    else $error("subcarrier not reset");
  sub_start_a: assert property ($rose(colour_mono_select) |-> ##[1:8] subcarrier)
    else $error("subcarrier slow to start");
  sub_shape_a: assert property ($fell(subcarrier) && colour_mono_select &&
    $past(colour_mono_select) && $past(colour_mono_select, 3) |->
    $past(subcarrier, 2) && !$past(subcarrier, 3)) else $error("subcarrier shape wrong");
  mono_entry_a: assert property (!colour_mono_select [*3] |-> ##[1:2] mono_active)
    else $error("mono not entered");
  pulse_keep_a: assert property ($rose(colour_mono_select) &&
    $past(colour_mono_select, 3) |-> !mono_active) else $error("short low left colour");
  field_vdrive_a: assert property (odd_field_pulse || even_field_pulse |-> v_drive)
    else $error("field pulse outside vertical drive");
endmodule : tsg_chk
bind tsg_top tsg_chk tsg_chk_inst (.clk(clk), .resetn(resetn),
  .colour_mono_select(colour_mono_select), .h_drive(h_drive), .v_drive(v_drive),
  .burst_flag(burst_flag), .odd_field_pulse(odd_field_pulse),
  .even_field_pulse(even_field_pulse), .subcarrier(subcarrier),
  .mono_active(mono_active), .genlock_locked(genlock_locked));

/* File: tb/tsg_master.sv */
// master composite sync source at mono rate, sync tip high
`timescale 1ns/1ps
module tsg_master (
  input wire logic clk,
  input wire logic run,
  output logic sync
);
  // ----------------
  // frame counters
  // ----------------
  logic [6:0] unit;
  logic [10:0] half;
  logic [9:0] h;
  // same clock as the slave, one phase only
  always_ff @(posedge clk) begin
    if (!run) begin
      unit <= 7'h00;
      half <= 11'h410;
    end else if (unit == 7'h40) begin
      unit <= 7'h00;
      half <= (half == 11'h419) ? 11'h000 : half + 11'h001;
    end else begin
      unit <= unit + 7'h01;
    end
  end
  always_comb begin
    h = (half >= 11'h20d) ? 10'(half - 11'h20d) : half[9:0];
    if (!run) sync = 1'b0;
    else if (h < 10'h006 || (h >= 10'h00c && h < 10'h012)) sync = unit < 7'h05;
    else if (h < 10'h00c) sync = unit < 7'h37;
    else sync = !half[0] && unit < 7'h0a;
  end
endmodule : tsg_master

/* File: tb/tsg_top_tb.sv */
// self-checking bench for the sync generator
`timescale 1ns/1ps
module tsg_top_tb;
  // ----------------
  // harness
  // ----------------
  logic clk, resetn, sel, run, cs_in, h_drive, v_drive, comp_sync, comp_blank;
  logic burst_flag, odd_p, even_p, subcarrier, mono_active, locked;
  logic [31:0] w, p;
  time t0;
  int fail_count, cmp_count;
  tsg_top #(.LOCK_ACQUIRE_CYC(70000)) tsg_top_inst (.clk(clk), .resetn(resetn),
    .colour_mono_select(sel), .comp_sync_in(cs_in), .h_drive(h_drive), .v_drive(v_drive),
    .comp_sync(comp_sync), .comp_blank(comp_blank), .burst_flag(burst_flag),
    .odd_field_pulse(odd_p), .even_field_pulse(even_p), .subcarrier(subcarrier),
    .mono_active(mono_active), .genlock_locked(locked));
  tsg_master tsg_master_inst (.clk(clk), .run(run), .sync(cs_in));
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
    if (s !== v) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, s, v);
      stop_test();
    end
  endtask : wait_for
  task automatic pulse(ref logic s, input int lim, output logic [31:0] wd,
                       output logic [31:0] pd);
    time a, b;
    wait_for(s, 1'b0, lim);
    wait_for(s, 1'b1, lim);
    a = $time;
    wait_for(s, 1'b0, lim);
    b = $time;
    wait_for(s, 1'b1, lim);
    wd = 32'((b - a) / 100);
    pd = 32'(($time - a) / 100);
  endtask : pulse
  // ----------------
  // scenarios
  // ----------------
  task automatic t_sub();
    pulse(subcarrier, 20, w, p);
    check(w, 32'h2);
    check(p, 32'h4);
    sel = 1'b0;
    @(negedge clk);
    @(negedge clk);
    check(subcarrier, 32'h0);
    sel = 1'b1;
    wait_for(subcarrier, 1'b1, 8);
    check(mono_active, 32'h0);
  endtask : t_sub
  task automatic t_colour();
    pulse(h_drive, 1000, w, p);
    check(w, 32'h5b);
    check(p, 32'h38e);
    pulse(burst_flag, 20000, w, p);
    check(w, 32'h23);
    check(p, 32'h38e);
    pulse(comp_sync, 1000, w, p);
    check(w, 32'h46);
    pulse(comp_blank, 20000, w, p);
    check(w, 32'h9a);
    check(p, 32'h38e);
  endtask : t_colour
  task automatic t_mono();
    int n;
    sel = 1'b0;
    wait_for(mono_active, 1'b1, 5);
    pulse(h_drive, 200, w, p);
    check(w, 32'hd);
    check(p, 32'h82);
    n = 0;
    repeat (130) begin
      @(negedge clk);
      if (burst_flag !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
  endtask : t_mono
  task automatic t_lock();
    run = 1'b1;
    wait_for(locked, 1'b1, 68250);
    wait_for(comp_sync, 1'b0, 200);
    wait_for(comp_sync, 1'b1, 200);
    t0 = $time;
    wait_for(cs_in, 1'b1, 20);
    w = 32'(($time - t0) / 100);
    check(w, 32'h4);
  endtask : t_lock
  task automatic t_field();
    wait_for(even_p, 1'b1, 40000);
    t0 = $time;
    wait_for(even_p, 1'b0, 100);
    check(32'(($time - t0) / 100), 32'h41);
    wait_for(v_drive, 1'b0, 2000);
    check(32'(($time - t0) / 100), 32'h492);
    wait_for(odd_p, 1'b1, 40000);
    check(32'(($time - t0) / 100), 32'h854d);
  endtask : t_field
  // ----------------
  // main sequence
  // ----------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    sel = 1'b1;
    run = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_sub();
    t_colour();
    t_mono();
    t_lock();
    t_field();
    stop_test();
  end
endmodule : tsg_top_tb
